// [rtl/cis_pkg.sv]
// Package: constants shared by the core input source selector design
package cis_pkg;

    // Register port geometry
    localparam int unsigned ADDR_W         = 8;
    localparam int unsigned DATA_W         = 8;

    // Register offsets on the control port
    localparam logic [7:0]  SEL01_OFFSET   = 8'h0F;
    localparam logic [7:0]  SEL23_OFFSET   = 8'h10;

    // Values after reset
    localparam logic [7:0]  SEL01_RESET    = 8'h10;
    localparam logic [7:0]  SEL23_RESET    = 8'h32;

    // Field positions inside each selector register
    localparam int unsigned LO_FIELD_LSB   = 0;
    localparam int unsigned HI_FIELD_LSB   = 4;
    localparam int unsigned CODE_W         = 4;

    // Stream geometry
    localparam int unsigned NUM_CHAN       = 4;
    localparam int unsigned NUM_SRC        = 6;
    localparam int unsigned SAMPLE_W       = 24;
    localparam int unsigned FRAME_W        = NUM_CHAN * SAMPLE_W;
    localparam int unsigned FIFO_DEPTH     = 8;

    // Source codes of a selector field
    typedef enum logic [3:0] {
        CIS_SRC_IN0   = 4'h0,
        CIS_SRC_IN1   = 4'h1,
        CIS_SRC_IN2   = 4'h2,
        CIS_SRC_IN3   = 4'h3,
        CIS_SRC_RATE0 = 4'hC,
        CIS_SRC_RATE1 = 4'hD
    } cis_src_e;

endpackage : cis_pkg

// [rtl/cis_fifo.sv]
// First-word-fall-through FIFO carrying routed sample frames to the core
`timescale 1ns/10ps
module cis_fifo
#(
    parameter int unsigned WIDTH = 96,
    parameter int unsigned DEPTH = 8
)
(
    input  wire logic             i_clock,    // System clock
    input  wire logic             i_arst_n,   // Async reset, active low
    input  wire logic             i_valid,    // Write side offers a word
    output logic                  o_ready,    // Room for a word
    input  wire logic [WIDTH-1:0] i_data,     // Word to store
    output logic                  o_valid,    // A word is waiting
    input  wire logic             i_ready,    // Read side takes the word
    output logic      [WIDTH-1:0] o_data      // Oldest word
);
    localparam int unsigned PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [PTR_W:0]   count_q;
    logic             push;
    logic             pop;

    // Honest full and empty come straight from the occupancy count
    assign o_ready = (count_q != DEPTH[PTR_W:0]);
    assign o_valid = (count_q != '0);
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;
    assign o_data  = mem_q[rd_ptr_q];

    // Storage has no reset; only pointers and count need a defined state
    always_ff @(posedge i_clock)
    begin
        if (push)
            mem_q[wr_ptr_q] <= i_data;
    end

    // Pointer and count bookkeeping
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_q <= PTR_W'(wr_ptr_q + 1'b1);
            if (pop)
                rd_ptr_q <= PTR_W'(rd_ptr_q + 1'b1);
            if (push && !pop)
                count_q <= (PTR_W+1)'(count_q + 1'b1);
            else if (pop && !push)
                count_q <= (PTR_W+1)'(count_q - 1'b1);
        end
    end

endmodule : cis_fifo

// [rtl/cis_chan_sel.sv]
// One channel's source multiplexer driven by a four-bit source code
`timescale 1ns/10ps
module cis_chan_sel
    import cis_pkg::*;
(
    input  wire logic [CODE_W-1:0]           i_code,    // Source code of the channel
    input  wire logic [NUM_SRC*SAMPLE_W-1:0] i_sources, // In0..In3, rate ch0, rate ch1
    output logic      [SAMPLE_W-1:0]         o_sample,  // Routed sample
    output logic                             o_bad_code // Code names no source
);
    logic code_in0;
    logic code_in1;
    logic code_in2;
    logic code_in3;
    logic code_rate0;
    logic code_rate1;

    // Decode the code table once
    assign code_in0   = (i_code == CIS_SRC_IN0);
    assign code_in1   = (i_code == CIS_SRC_IN1);
    assign code_in2   = (i_code == CIS_SRC_IN2);
    assign code_in3   = (i_code == CIS_SRC_IN3);
    assign code_rate0 = (i_code == CIS_SRC_RATE0);
    assign code_rate1 = (i_code == CIS_SRC_RATE1);
    assign o_bad_code = !(code_in0 || code_in1 || code_in2 || code_in3 ||
                          code_rate0 || code_rate1);

    // Reserved codes route silence rather than stale or mixed data
    assign o_sample =
        code_in0   ? i_sources[0*SAMPLE_W +: SAMPLE_W] :
        code_in1   ? i_sources[1*SAMPLE_W +: SAMPLE_W] :
        code_in2   ? i_sources[2*SAMPLE_W +: SAMPLE_W] :
        code_in3   ? i_sources[3*SAMPLE_W +: SAMPLE_W] :
        code_rate0 ? i_sources[4*SAMPLE_W +: SAMPLE_W] :
        code_rate1 ? i_sources[5*SAMPLE_W +: SAMPLE_W] :
                     '0;

endmodule : cis_chan_sel

// [rtl/cis_core_input_select.sv]
// Top of the core input source selector: registers, routing and frame FIFO
`timescale 1ns/10ps
//
// The block holds two selector registers on the control port. Each
// four-bit field picks one of six sources for one core input channel.
// Selections are copied into the routing path only when a sample
// boundary strobe arrives, so a register write in the middle of a
// sample period never splices two sources into one sample. The four
// routed samples of one boundary form one frame that is queued in an
// eight-deep FIFO on its way to the core.
//
// Programming model
//   The first selector register holds the
//   channel 0 code in bits 3:0 and the channel 1
//   code in bits 7:4. The second one does the
//   same for channels 2 and 3. Both are plain
//   read/write registers: a read returns what was
//   last written, codes without a source too.
//
// Source codes
//   0x0 to 0x3  converter or mic inputs 0 to 3
//   0xC         rate converter channel 0
//   0xD         rate converter channel 1
//   other       no source: the channel carries
//               zero samples and the bad-code
//               status rises on the same edge as the
//               code comes into force
//
// Control port timing
//   Writes and reads are one-cycle strobes taken
//   on the rising edge, back to back if wanted.
//   A write is seen by a read on the next cycle.
//   Read data comes one cycle after the strobe
//   with a one-cycle valid pulse, then holds
//   until the next read. A read sharing a cycle
//   with a write returns the value from before
//   it. Unmapped addresses read zero and ignore
//   writes.
//
// Boundary timing
//   The boundary strobe is a one-cycle pulse in
//   this clock domain. On that edge the four
//   samples are taken from the sources as they
//   stand, routed with the register values from
//   before the edge, and pushed as one frame.
//   The selections in force change on that edge
//   and at no other time.
//
// Queue
//   Eight frames, falling through: the head frame
//   stands on the core outputs while valid is
//   high, until the core takes it. Channel 0 is
//   in the low bits of a frame. Boundaries cannot
//   wait, so one that meets a full queue loses
//   its frame and sets a sticky flag. A boundary
//   on the edge of a pop still sees a full queue;
//   this keeps the core's ready input out of the
//   path to the ready output.
//
// Reset
//   The asynchronous reset loads 0x10 and 0x32
//   into the registers and the selections in
//   force, so channel n takes input n at once.
//   It empties the queue and clears read valid,
//   read data, the drop flag and the bad-code
//   status. Requests may start at the first edge
//   after release.
//
// Hazards and limits
//   A write on a boundary cycle waits for the
//   next boundary; to change a given frame, write
//   at least one cycle before its boundary.
//   Reserved codes are stored, not refused, so a
//   read-back always shows what software did.
//   Sources must already be settled in this clock
//   domain; no synchroniser sits on them.
//   The bad-code status is a level, not sticky.
//   Queue storage has no reset, so the core
//   outputs are undefined until the first frame;
//   valid low marks this.
module cis_core_input_select
    import cis_pkg::*;
(
    input  wire logic                i_clock,         // System clock, 20 MHz
    input  wire logic                i_arst_n,        // Async reset, active low
    // Control port
    input  wire logic                i_reg_wr_en,     // Write strobe, one cycle
    input  wire logic                i_reg_rd_en,     // Read strobe, one cycle
    input  wire logic [ADDR_W-1:0]   i_reg_addr,      // Register address
    input  wire logic [DATA_W-1:0]   i_reg_wdata,     // Write data
    output logic      [DATA_W-1:0]   o_reg_rdata,     // Read data, registered
    output logic                     o_reg_rd_valid,  // Read data valid pulse
    // Sources, same clock domain
    input  wire logic                i_sample_strobe, // Sample boundary pulse
    input  wire logic [SAMPLE_W-1:0] i_conv_in0,      // converter_or_mic_input_0
    input  wire logic [SAMPLE_W-1:0] i_conv_in1,      // converter_or_mic_input_1
    input  wire logic [SAMPLE_W-1:0] i_conv_in2,      // converter_or_mic_input_2
    input  wire logic [SAMPLE_W-1:0] i_conv_in3,      // converter_or_mic_input_3
    input  wire logic [SAMPLE_W-1:0] i_rate_ch0,      // Rate converter channel 0
    input  wire logic [SAMPLE_W-1:0] i_rate_ch1,      // Rate converter channel 1
    // Stream toward the core
    output logic                     o_frame_ready,   // FIFO can take a frame
    output logic                     o_core_valid,    // Frame waiting for core
    input  wire logic                i_core_ready,    // Core takes the frame
    output logic      [SAMPLE_W-1:0] o_core_ch0,      // Core input channel 0
    output logic      [SAMPLE_W-1:0] o_core_ch1,      // Core input channel 1
    output logic      [SAMPLE_W-1:0] o_core_ch2,      // Core input channel 2
    output logic      [SAMPLE_W-1:0] o_core_ch3,      // Core input channel 3
    // Status
    output logic      [DATA_W-1:0]   o_active_sel01,  // Selection in force, ch0/ch1
    output logic      [DATA_W-1:0]   o_active_sel23,  // Selection in force, ch2/ch3
    output logic                     o_bad_code,      // A channel routes silence
    output logic                     o_frame_dropped  // Sticky: frame lost on full
);

    // Software-visible selector registers
    logic [DATA_W-1:0] sel01_q;
    logic [DATA_W-1:0] sel23_q;

    // Selections in force on the routing path
    logic [DATA_W-1:0] act01_q;
    logic [DATA_W-1:0] act23_q;

    // Read answer and status flops
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic              rd_valid_q;
    logic              dropped_q;
    logic              bad_q;

    // Decoded register port
    logic              hit01;
    logic              hit23;
    logic              wr01;
    logic              wr23;

    // Routing path
    logic [DATA_W-1:0]           next01;
    logic [DATA_W-1:0]           next23;
    logic [CODE_W-1:0]           code  [NUM_CHAN];
    logic [SAMPLE_W-1:0]         routed[NUM_CHAN];
    logic [NUM_CHAN-1:0]         bad_chan;
    logic [NUM_SRC*SAMPLE_W-1:0] sources;
    logic [FRAME_W-1:0]          frame_in;
    logic [FRAME_W-1:0]          frame_out;
    logic                        fifo_in_ready;

    // Address decode for both selector registers
    assign hit01 = (i_reg_addr == SEL01_OFFSET);
    assign hit23 = (i_reg_addr == SEL23_OFFSET);
    assign wr01  = i_reg_wr_en && hit01;
    assign wr23  = i_reg_wr_en && hit23;

    // Unmapped addresses read as zero and ignore writes
    assign rdata_d = hit01 ? sel01_q :
                     hit23 ? sel23_q :
                             '0;

    // Selector registers keep whatever software writes; reserved codes are
    // stored as written because the far side promises not to use them
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            sel01_q <= SEL01_RESET;
            sel23_q <= SEL23_RESET;
        end
        else
        begin
            if (wr01)
                sel01_q <= i_reg_wdata;
            if (wr23)
                sel23_q <= i_reg_wdata;
        end
    end

    // Read answer one cycle after the strobe
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rdata_q    <= '0;
            rd_valid_q <= 1'b0;
        end
        else
        begin
            rd_valid_q <= i_reg_rd_en;
            if (i_reg_rd_en)
                rdata_q <= rdata_d;
        end
    end

    assign o_reg_rdata    = rdata_q;
    assign o_reg_rd_valid = rd_valid_q;

    // A write landing on the boundary cycle is not yet visible in the
    // register, so the routing uses the register value before that write;
    // the new value then waits for the next boundary
    assign next01 = i_sample_strobe ? sel01_q : act01_q;
    assign next23 = i_sample_strobe ? sel23_q : act23_q;

    // Selections in force change only on a boundary
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            act01_q <= SEL01_RESET;
            act23_q <= SEL23_RESET;
        end
        else
        begin
            act01_q <= next01;
            act23_q <= next23;
        end
    end

    // Split the selections into per-channel codes
    assign code[0] = next01[LO_FIELD_LSB +: CODE_W];
    assign code[1] = next01[HI_FIELD_LSB +: CODE_W];
    assign code[2] = next23[LO_FIELD_LSB +: CODE_W];
    assign code[3] = next23[HI_FIELD_LSB +: CODE_W];

    // Sources in code order, rate converter channels after the four inputs
    assign sources = {i_rate_ch1, i_rate_ch0,
                      i_conv_in3, i_conv_in2, i_conv_in1, i_conv_in0};

    // One multiplexer per core input channel
    for (genvar ch = 0; ch < NUM_CHAN; ch++)
    begin : g_chan
        cis_chan_sel u_sel (
            .i_code     (code[ch]),
            .i_sources  (sources),
            .o_sample   (routed[ch]),
            .o_bad_code (bad_chan[ch])
        );
        assign frame_in[ch*SAMPLE_W +: SAMPLE_W] = routed[ch];
    end

    // Frame queue between the boundary and the core; a slow core fills it
    cis_fifo #(
        .WIDTH (FRAME_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clock  (i_clock),
        .i_arst_n (i_arst_n),
        .i_valid  (i_sample_strobe),
        .o_ready  (fifo_in_ready),
        .i_data   (frame_in),
        .o_valid  (o_core_valid),
        .i_ready  (i_core_ready),
        .o_data   (frame_out)
    );

    assign o_frame_ready = fifo_in_ready;

    // Boundaries cannot be held off, so a full queue loses the frame and
    // says so; the flag clears only by reset
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
            dropped_q <= 1'b0;
        else if (i_sample_strobe && !fifo_in_ready)
            dropped_q <= 1'b1;
    end

    // Reserved code in force; mostly a debug aid for the far side's promise
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
            bad_q <= 1'b0;
        else
            bad_q <= |bad_chan;
    end

    // Frame fields toward the core, channel 0 in the low bits
    assign o_core_ch0      = frame_out[0*SAMPLE_W +: SAMPLE_W];
    assign o_core_ch1      = frame_out[1*SAMPLE_W +: SAMPLE_W];
    assign o_core_ch2      = frame_out[2*SAMPLE_W +: SAMPLE_W];
    assign o_core_ch3      = frame_out[3*SAMPLE_W +: SAMPLE_W];
    assign o_active_sel01  = act01_q;
    assign o_active_sel23  = act23_q;
    assign o_bad_code      = bad_q;
    assign o_frame_dropped = dropped_q;

endmodule : cis_core_input_select

// [bench/cis_sel_props.sv]
// Checker: port-level properties of the core input source selector
`timescale 1ns/10ps
module cis_sel_props
    import cis_pkg::*;
(
    input  wire logic                i_clock,         // System clock
    input  wire logic                i_arst_n,        // Async reset, active low
    input  wire logic                i_reg_wr_en,     // Write strobe
    input  wire logic                i_reg_rd_en,     // Read strobe
    input  wire logic [ADDR_W-1:0]   i_reg_addr,      // Register address
    input  wire logic [DATA_W-1:0]   i_reg_wdata,     // Write data
    input  wire logic [DATA_W-1:0]   o_reg_rdata,     // Read data
    input  wire logic                o_reg_rd_valid,  // Read data valid
    input  wire logic                i_sample_strobe, // Sample boundary
    input  wire logic                o_frame_ready,   // FIFO has room
    input  wire logic                o_core_valid,    // Frame waiting
    input  wire logic                i_core_ready,    // Core takes frame
    input  wire logic [SAMPLE_W-1:0] o_core_ch0,      // Head frame, channel 0
    input  wire logic [DATA_W-1:0]   o_active_sel01,  // Selection in force
    input  wire logic [DATA_W-1:0]   o_active_sel23,  // Selection in force
    input  wire logic                o_bad_code,      // Reserved code in force
    input  wire logic                o_frame_dropped  // Sticky drop flag
);
    logic [7:0] sh01_q;
    logic [7:0] sh23_q;
    wire        unmapped = i_reg_addr != SEL01_OFFSET && i_reg_addr != SEL23_OFFSET;

    // A code outside the table routes silence and must raise the status
    function automatic logic is_rsv(input logic [3:0] c);
        return !(c < 4'h4 || c == 4'hC || c == 4'hD);
    endfunction : is_rsv

    wire        sh_bad = is_rsv(sh01_q[3:0]) || is_rsv(sh01_q[7:4]) ||
                         is_rsv(sh23_q[3:0]) || is_rsv(sh23_q[7:4]);

    // Shadow registers: what the next boundary must bring into force
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            sh01_q <= SEL01_RESET;
            sh23_q <= SEL23_RESET;
        end
        else if (i_reg_wr_en && i_reg_addr == SEL01_OFFSET)
            sh01_q <= i_reg_wdata;
        else if (i_reg_wr_en && i_reg_addr == SEL23_OFFSET)
            sh23_q <= i_reg_wdata;
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_arst_n);

    a_read_latency: assert property (i_reg_rd_en |=> o_reg_rd_valid)
        else $error("read valid missing one cycle after read");
    a_read_cause: assert property (o_reg_rd_valid |-> $past(i_reg_rd_en))
        else $error("read valid without a read");
    a_read_sel01: assert property (i_reg_rd_en && i_reg_addr == SEL01_OFFSET
        |=> o_reg_rdata == $past(sh01_q)) else $error("first selector read wrong");
    a_read_sel23: assert property (i_reg_rd_en && i_reg_addr == SEL23_OFFSET
        |=> o_reg_rdata == $past(sh23_q)) else $error("second selector read wrong");
    a_read_unmapped: assert property (i_reg_rd_en && unmapped |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_apply_boundary: assert property (i_sample_strobe |=> o_active_sel01 == $past(sh01_q)
        && o_active_sel23 == $past(sh23_q)) else $error("selection not applied at boundary");
    a_hold_between: assert property (!i_sample_strobe |=>
        $stable(o_active_sel01) && $stable(o_active_sel23)) else $error("selection moved");
    a_push_frame: assert property (i_sample_strobe && o_frame_ready |=> o_core_valid)
        else $error("frame not queued");
    a_drop_flag: assert property (i_sample_strobe && !o_frame_ready |=> o_frame_dropped)
        else $error("drop on full not flagged");
    a_bad_status: assert property (i_sample_strobe |=> o_bad_code == $past(sh_bad))
        else $error("bad-code status wrong after boundary");
    a_drop_sticky: assert property (o_frame_dropped |=> o_frame_dropped)
        else $error("drop flag cleared");
    a_head_hold: assert property (o_core_valid && !i_core_ready |=>
        o_core_valid && $stable(o_core_ch0)) else $error("head frame not held");
endmodule : cis_sel_props

bind cis_core_input_select cis_sel_props chk_u (
    .i_clock, .i_arst_n, .i_reg_wr_en, .i_reg_rd_en, .i_reg_addr, .i_reg_wdata,
    .o_reg_rdata, .o_reg_rd_valid, .i_sample_strobe, .o_frame_ready, .o_core_valid,
    .i_core_ready, .o_core_ch0, .o_active_sel01, .o_active_sel23, .o_bad_code,
    .o_frame_dropped
);

// [bench/testbench.sv]
// Testbench: register port, source routing, boundary timing and frame queue
`timescale 1ns/10ps
module testbench
    import cis_pkg::*;
;
    logic        i_clock, i_arst_n, i_reg_wr_en, i_reg_rd_en, i_sample_strobe, i_core_ready;
    logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata, o_active_sel01, o_active_sel23;
    logic [23:0] i_conv_in0, i_conv_in1, i_conv_in2, i_conv_in3, i_rate_ch0, i_rate_ch1;
    logic [23:0] o_core_ch0, o_core_ch1, o_core_ch2, o_core_ch3;
    logic        o_reg_rd_valid, o_frame_ready, o_core_valid, o_bad_code, o_frame_dropped;
    logic [7:0]  sh01, sh23, rd_q[$];
    logic [95:0] fr_q[$];
    logic [31:0] rng = 32'h000033DF;
    logic [3:0]  codes[7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hC, 4'hD, 4'h7};
    int          error_cnt = 0;
    int          total_checks = 0;

    cis_core_input_select dut_u (
        .i_clock, .i_arst_n, .i_reg_wr_en, .i_reg_rd_en, .i_reg_addr, .i_reg_wdata,
        .o_reg_rdata, .o_reg_rd_valid, .i_sample_strobe, .i_conv_in0, .i_conv_in1,
        .i_conv_in2, .i_conv_in3, .i_rate_ch0, .i_rate_ch1, .o_frame_ready, .o_core_valid,
        .i_core_ready, .o_core_ch0, .o_core_ch1, .o_core_ch2, .o_core_ch3, .o_active_sel01,
        .o_active_sel23, .o_bad_code, .o_frame_dropped
    );

    // Free-running clock, 50 ns period
    initial
    begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end

    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : xs

    // Expected sample for one code; reserved codes give silence
    function automatic logic [23:0] route(input logic [3:0] c);
        case (c)
            4'h0: return i_conv_in0;
            4'h1: return i_conv_in1;
            4'h2: return i_conv_in2;
            4'h3: return i_conv_in3;
            4'hC: return i_rate_ch0;
            4'hD: return i_rate_ch1;
            default: return 24'h000000;
        endcase
    endfunction : route

    task automatic chkr(input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("BAD %0t value got %h want %h", $time, g, e);
        end
    endtask : chkr

    task automatic chkf(input logic [95:0] e, input logic [95:0] g);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("BAD %0t frame got %h want %h", $time, g, e);
        end
    endtask : chkf

    // One bus cycle: optional boundary, write and read; expectations noted first
    task automatic cyc(input logic s, w, r, input logic [7:0] a, d);
        @(negedge i_clock);
        i_conv_in0 = 24'(xs());
        i_conv_in1 = 24'(xs());
        i_conv_in2 = 24'(xs());
        i_conv_in3 = 24'(xs());
        i_rate_ch0 = 24'(xs());
        i_rate_ch1 = 24'(xs());
        {i_sample_strobe, i_reg_wr_en, i_reg_rd_en, i_reg_addr, i_reg_wdata} = {s, w, r, a, d};
        if (s && fr_q.size() < FIFO_DEPTH)
            fr_q.push_back({route(sh23[7:4]), route(sh23[3:0]),
                            route(sh01[7:4]), route(sh01[3:0])});
        if (r)
            rd_q.push_back(a == SEL01_OFFSET ? sh01 : a == SEL23_OFFSET ? sh23 : 8'h00);
        @(negedge i_clock);
        {i_sample_strobe, i_reg_wr_en, i_reg_rd_en} = 3'b000;
        // Shadow moves only after the boundary used the old value
        if (w && a == SEL01_OFFSET)
            sh01 = d;
        if (w && a == SEL23_OFFSET)
            sh23 = d;
    endtask : cyc

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run

    // Monitor: each result takes the oldest note of its kind
    always @(posedge i_clock)
    begin
        if (o_reg_rd_valid === 1'b1)
            chkr(rd_q.pop_front(), o_reg_rdata);
        if (o_core_valid === 1'b1 && i_core_ready === 1'b1)
            chkf(fr_q.pop_front(), {o_core_ch3, o_core_ch2, o_core_ch1, o_core_ch0});
    end

    // Watchdog: the whole sequence needs well under 2000 cycles
    initial
    begin
        #100000;
        error_cnt++;
        $display("BAD %0t watchdog expired", $time);
        complete_run();
    end

    initial
    begin
        {i_arst_n, i_reg_wr_en, i_reg_rd_en, i_sample_strobe, i_reg_addr, i_reg_wdata} = '0;
        {i_conv_in0, i_conv_in1, i_conv_in2, i_conv_in3, i_rate_ch0, i_rate_ch1} = '0;
        i_core_ready = 1'b1;
        sh01 = SEL01_RESET;
        sh23 = SEL23_RESET;
        repeat (12) @(posedge i_clock);
        @(negedge i_clock);
        i_arst_n = 1'b1;
        // Reset values, unmapped write ignored, unmapped read gives zero
        cyc(1'b0, 1'b1, 1'b0, 8'h11, 8'hFF);
        cyc(1'b0, 1'b0, 1'b1, SEL01_OFFSET, 8'h00);
        cyc(1'b0, 1'b0, 1'b1, SEL23_OFFSET, 8'h00);
        cyc(1'b0, 1'b0, 1'b1, 8'h11, 8'h00);
        cyc(1'b1, 1'b0, 1'b0, 8'h00, 8'h00);
        $display("test reset values done");
        // Every code on every channel; reserved 0111 proves silence
        for (int i = 0; i < 7; i++)
        begin
            cyc(1'b0, 1'b1, 1'b0, SEL01_OFFSET, {codes[(i+1)%7], codes[i]});
            cyc(1'b0, 1'b1, 1'b1, SEL23_OFFSET, {codes[(i+3)%7], codes[(i+2)%7]});
            cyc(1'b0, 1'b0, 1'b1, SEL01_OFFSET, 8'h00);
            cyc(1'b1, 1'b0, 1'b1, SEL23_OFFSET, 8'h00);
        end
        $display("test source codes done");
        // Write on the boundary cycle: old selection applies to that frame
        cyc(1'b1, 1'b1, 1'b0, SEL01_OFFSET, 8'h3D);
        cyc(1'b1, 1'b0, 1'b0, 8'h00, 8'h00);
        $display("test boundary write done");
        // Fill the frame queue with the core stalled, then drain it
        repeat (2) @(negedge i_clock);
        i_core_ready = 1'b0;
        repeat (FIFO_DEPTH + 1) cyc(1'b1, 1'b0, 1'b0, 8'h00, 8'h00);
        chkr(8'h00, {7'h00, o_frame_ready});
        chkr(8'h01, {7'h00, o_frame_dropped});
        i_core_ready = 1'b1;
        for (int n = 0; n < 40 && o_core_valid !== 1'b0; n++)
            @(negedge i_clock);
        chkr(8'h00, {7'h00, o_core_valid});
        chkr(8'h00, 8'(fr_q.size()));
        $display("test queue fill done");
        // Mid-run reset restores both selectors and clears the drop flag
        i_arst_n = 1'b0;
        sh01 = SEL01_RESET;
        sh23 = SEL23_RESET;
        @(negedge i_clock);
        i_arst_n = 1'b1;
        chkr(8'h00, {7'h00, o_frame_dropped});
        cyc(1'b0, 1'b0, 1'b1, SEL01_OFFSET, 8'h00);
        cyc(1'b0, 1'b0, 1'b1, SEL23_OFFSET, 8'h00);
        @(negedge i_clock);
        chkr(8'h00, 8'(rd_q.size()));
        $display("test mid-run reset done");
        complete_run();
    end
endmodule : testbench
